// ===== hdl/pfc_top.sv
// host controller for a byte-wide parallel flash, driven by software over apb
// assumes the flash pins are synchronous to CLK_SYS and the bench resolves the data wire
// Functional notes
// (RL1) sector is address bits 18..16, 64K each
// (RL2) read: ce, oe low, we high
// (RL3) flash floats data when ce or oe high
// (RL4) command write: we, ce low, oe high
// (RL5) address latched at later falling strobe
// (RL6) data latched at earlier rising strobe
// (RL7) flash starts in read-array mode
// (RL8) flash returns to read-array after operation
// (RL9) suspend halts erase, settles, then reads
// (RL10) suspended erase sector reads give status
// (RL11) program allowed during erase suspend
// (RL12) on failure, host sends reset before reads
// (RL13) id sequence enters identification mode
// (RL14) id reads repeat without new sequence
// (RL15) lowest address bit picks maker/device code
// (RL16) host writes reset to leave id mode
// (RL17) high-voltage bit nine gives id mode
// (RL18) host writes only defined command sequences; OP_WRITE sends any single byte at any address
// (RL19) operation starts only after full sequence
// (RL20) completion seen through poll and toggle bits
// (RL21) id entry: aa/555, 55/2aa, 90/555
// (RL22) f0 anywhere is the reset command
// (RL23) reset ignored during a running operation
// (RL24) toggle alternates while busy, bit five fails
// (RL25) operation durations are flash parameters
`timescale 1ns/1ps
`default_nettype none
module pfc_top #(
	parameter int PULSE = pfc_pkg::PULSE_CYC,
	parameter int GAP   = pfc_pkg::GAP_CYC
) (
	// clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        RST_N,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// flash pins
	output logic [18:0]      FL_ADDR,
	input  wire logic [7:0]  FL_DQ_I,
	output logic [7:0]       FL_DQ_O,
	output logic             FL_DQ_OE,
	output logic             FL_CE_N,
	output logic             FL_OE_N,
	output logic             FL_WE_N,
	output logic             FL_ID_HV
);
	typedef enum logic [3:0] {
		S_IDLE   = 4'b0001,
		S_CYC    = 4'b0010,
		S_POLL   = 4'b0100,
		S_FAILRS = 4'b1000
	} pfc_st_t;

	typedef struct packed {
		logic        wr;
		logic        hv;
		logic [18:0] a;
		logic [7:0]  d;
	} pfc_step_t;

	typedef struct packed {
		pfc_st_t         st;
		pfc_pkg::pfc_op_t op;
		logic [2:0]      step;
		logic [18:0]     addr;
		logic [7:0]      wdata;
		logic [7:0]      rdata;
		logic            fail;
		logic            id_mode;
		logic            suspended;
		logic            have_prev;
		logic            prev_tog;
		logic            start;
		pfc_step_t       cyc;
		logic [31:0]     prdata;
		logic            pready;
		logic            pslverr;
	} pfc_top_st_t;

	pfc_top_st_t s;
	pfc_top_st_t next_s;
	logic        cyc_done;
	logic [7:0]  cyc_rdata;

	function automatic logic [2:0] op_len(input pfc_pkg::pfc_op_t op);
		case (op)
			pfc_pkg::OP_ID_ENTER:   op_len = 3'd3;
			pfc_pkg::OP_PROGRAM:    op_len = 3'd4;
			pfc_pkg::OP_SECT_ERASE: op_len = 3'd6;
			pfc_pkg::OP_CHIP_ERASE: op_len = 3'd6;
			default:                op_len = 3'd1;
		endcase
	endfunction : op_len

	// every sequence the host emits is a defined one, except OP_WRITE, which sends any byte from software, and an undefined op code, which sends a lone aa/555 [RL18]
	function automatic pfc_step_t op_step(input pfc_pkg::pfc_op_t op, input logic [2:0] k,
		input logic [18:0] a, input logic [7:0] d);
		op_step = '{wr: 1'b1, hv: 1'b0, a: a, d: d};
		case (op)
			pfc_pkg::OP_READ:
				op_step.wr = 1'b0;
			pfc_pkg::OP_HV_ID:
			begin
				op_step.wr                         = 1'b0;
				op_step.hv                         = 1'b1; // [RL17]
				op_step.a[pfc_pkg::SECOND_ADDR_BIT] = 1'b0; // [RL17]
			end
			pfc_pkg::OP_RESET:   op_step.d = pfc_pkg::CMD_RESET; // [RL22]
			pfc_pkg::OP_SUSPEND: op_step.d = pfc_pkg::CMD_SUSPEND; // [RL9]
			pfc_pkg::OP_RESUME:  op_step.d = pfc_pkg::CMD_RESUME;
			pfc_pkg::OP_WRITE:   op_step.d = d;
			default:
				// unlock pair, command, and for erase a second unlock pair [RL21]
				case (k)
					3'd0, 3'd3:
						if (!(k == 3'd3 && op == pfc_pkg::OP_PROGRAM))
						begin
							op_step.a = pfc_pkg::UNLOCK_ADDR1;
							op_step.d = pfc_pkg::UNLOCK_DATA1;
						end
					3'd1, 3'd4:
					begin
						op_step.a = pfc_pkg::UNLOCK_ADDR2;
						op_step.d = pfc_pkg::UNLOCK_DATA2;
					end
					3'd2:
					begin
						op_step.a = pfc_pkg::UNLOCK_ADDR1;
						op_step.d = (op == pfc_pkg::OP_ID_ENTER) ? pfc_pkg::CMD_ID_ENTER :
							(op == pfc_pkg::OP_PROGRAM) ? pfc_pkg::CMD_PROGRAM : pfc_pkg::CMD_ERASE_SETUP;
					end
					default:
						if (op == pfc_pkg::OP_CHIP_ERASE)
						begin
							op_step.a = pfc_pkg::UNLOCK_ADDR1;
							op_step.d = pfc_pkg::CMD_CHIP_ERASE;
						end
						else
							op_step.d = pfc_pkg::CMD_SECT_ERASE; // sector from addr [RL1]
				endcase
		endcase
	endfunction : op_step

	logic                apb_acc;
	logic                apb_setup;
	logic                launch;
	logic                tog;
	pfc_pkg::pfc_op_t    wr_op;

	always_comb
	begin
		next_s        = s;
		next_s.start  = 1'b0;
		apb_setup     = PSEL & ~PENABLE;
		apb_acc       = PSEL & PENABLE & s.pready;
		wr_op         = pfc_pkg::pfc_op_t'(PWDATA[pfc_pkg::CTRL_OP_LSB +: pfc_pkg::OP_W]);
		launch        = apb_acc & PWRITE & (PADDR == pfc_pkg::REG_CTRL) & (s.st == S_IDLE);
		tog           = cyc_rdata[pfc_pkg::TOGGLE_FLAG_BIT];

		// zero-wait apb: answer formed in setup, shown in access
		next_s.pready  = apb_setup;
		next_s.pslverr = 1'b0;
		if (apb_setup)
		begin
			next_s.prdata = '0;
			case (PADDR)
				pfc_pkg::REG_CTRL:   next_s.prdata[pfc_pkg::OP_W-1:0] = s.op;
				pfc_pkg::REG_ADDR:   next_s.prdata[18:0] = s.addr;
				pfc_pkg::REG_WDATA:  next_s.prdata[7:0]  = s.wdata;
				pfc_pkg::REG_RDATA:  next_s.prdata[7:0]  = s.rdata;
				pfc_pkg::REG_STATUS:
				begin
					next_s.prdata[pfc_pkg::ST_BUSY]      = (s.st != S_IDLE);
					next_s.prdata[pfc_pkg::ST_FAIL]      = s.fail;
					next_s.prdata[pfc_pkg::ST_ID_MODE]   = s.id_mode;
					next_s.prdata[pfc_pkg::ST_SUSPENDED] = s.suspended;
					next_s.prdata[pfc_pkg::ST_SECTOR_LSB +: pfc_pkg::SECTOR_W] =
						s.addr[pfc_pkg::SECTOR_LSB +: pfc_pkg::SECTOR_W]; // [RL1]
				end
				default:             next_s.pslverr = 1'b1;
			endcase
		end
		// address and data hold still while an operation runs
		if (apb_acc & PWRITE & (s.st == S_IDLE))
		begin
			if (PADDR == pfc_pkg::REG_ADDR)
				next_s.addr = PWDATA[18:0];
			if (PADDR == pfc_pkg::REG_WDATA)
				next_s.wdata = PWDATA[7:0];
		end

		case (s.st)
			S_IDLE:
				if (launch)
				begin
					next_s.op    = wr_op;
					next_s.step  = 3'd0;
					next_s.fail  = 1'b0;
					next_s.cyc   = op_step(wr_op, 3'd0, s.addr, s.wdata);
					next_s.start = 1'b1;
					next_s.st    = S_CYC;
				end
			S_CYC:
				if (cyc_done)
				begin
					if (s.step != op_len(s.op) - 3'd1)
					begin
						next_s.step  = s.step + 3'd1;
						next_s.cyc   = op_step(s.op, s.step + 3'd1, s.addr, s.wdata);
						next_s.start = 1'b1;
					end
					else
					begin
						next_s.st = S_IDLE;
						case (s.op)
							pfc_pkg::OP_READ, pfc_pkg::OP_HV_ID:
								next_s.rdata = cyc_rdata; // [RL14] [RL15]
							pfc_pkg::OP_ID_ENTER:
								next_s.id_mode = 1'b1; // [RL13]
							pfc_pkg::OP_RESET:
								next_s.id_mode = 1'b0; // [RL16]
							pfc_pkg::OP_PROGRAM, pfc_pkg::OP_SECT_ERASE, pfc_pkg::OP_CHIP_ERASE,
							pfc_pkg::OP_SUSPEND, pfc_pkg::OP_RESUME:
							begin
								// full sequence sent, now poll until the flash settles [RL19] [RL20]
								next_s.suspended = (s.op == pfc_pkg::OP_SUSPEND) |
									(s.suspended & (s.op == pfc_pkg::OP_PROGRAM)); // [RL9] [RL11]
								next_s.have_prev = 1'b0;
								next_s.cyc       = '{wr: 1'b0, hv: 1'b0, a: s.addr, d: s.wdata};
								next_s.start     = 1'b1;
								next_s.st        = S_POLL;
							end
							default: ;
						endcase
					end
				end
			S_POLL:
				if (cyc_done)
				begin
					next_s.rdata = cyc_rdata;
					if (s.have_prev && tog == s.prev_tog)
						next_s.st = S_IDLE; // toggle stopped [RL8] [RL24]
					else if (s.have_prev && cyc_rdata[pfc_pkg::FAIL_FLAG_BIT] && s.rdata[pfc_pkg::FAIL_FLAG_BIT])
					begin
						// toggling, fail bit up on two reads running: only now is reset accepted [RL12] [RL23]
						next_s.fail  = 1'b1;
						next_s.cyc   = '{wr: 1'b1, hv: 1'b0, a: s.addr, d: pfc_pkg::CMD_RESET};
						next_s.start = 1'b1;
						next_s.st    = S_FAILRS;
					end
					else
					begin
						next_s.have_prev = 1'b1;
						next_s.prev_tog  = tog; // [RL24]
						next_s.start     = 1'b1;
					end
				end
			S_FAILRS:
				if (cyc_done)
				begin
					next_s.id_mode = 1'b0; // [RL12]
					next_s.st      = S_IDLE;
				end
			default:
				next_s.st = S_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			s    <= '0;
			s.st <= S_IDLE;
			s.op <= pfc_pkg::OP_READ;
		end
		else
			s <= next_s;
	end

	// the cycle engine floats data whenever it is not writing [RL3]
	pfc_cyc #(
		.PULSE (PULSE),
		.GAP   (GAP)
	) u_cyc (
		.clk      (CLK_SYS),
		.rst_n    (RST_N),
		.start    (s.start),
		.wr       (s.cyc.wr),
		.hv       (s.cyc.hv),
		.addr     (s.cyc.a),
		.wdata    (s.cyc.d),
		.done     (cyc_done),
		.rdata    (cyc_rdata),
		.fl_addr  (FL_ADDR),
		.fl_dq_i  (FL_DQ_I),
		.fl_dq_o  (FL_DQ_O),
		.fl_dq_oe (FL_DQ_OE),
		.fl_ce_n  (FL_CE_N),
		.fl_oe_n  (FL_OE_N),
		.fl_we_n  (FL_WE_N),
		.fl_hv    (FL_ID_HV)
	);

	assign PRDATA  = s.prdata;
	assign PREADY  = s.pready;
	assign PSLVERR = s.pslverr;
endmodule : pfc_top
`default_nettype wire

// ===== hdl/pfc_pkg.sv
// constants for the parallel flash host controller: apb map, flash commands, status bits, timing
// assumes a byte-wide flash with active-low strobes and a 200 MHz system clock
package pfc_pkg;
	localparam int          ADDR_W          = 19;
	localparam int          DATA_W          = 8;
	localparam int          PADDR_W         = 12;
	localparam int          CNT_W           = 8;

	// apb register offsets
	localparam logic [11:0] REG_CTRL        = 12'h000;
	localparam logic [11:0] REG_ADDR        = 12'h004;
	localparam logic [11:0] REG_WDATA       = 12'h008;
	localparam logic [11:0] REG_RDATA       = 12'h00c;
	localparam logic [11:0] REG_STATUS      = 12'h010;

	// ctrl and status fields
	localparam int          CTRL_OP_LSB     = 0;
	localparam int          OP_W            = 4;
	localparam int          ST_BUSY         = 0;
	localparam int          ST_FAIL         = 1;
	localparam int          ST_ID_MODE      = 2;
	localparam int          ST_SUSPENDED    = 3;
	localparam int          ST_SECTOR_LSB   = 4;

	// sector select from the top address bits
	localparam int          SECTOR_LSB      = 16;
	localparam int          SECTOR_W        = 3;

	// flash status bits on the data lines, and the address bit held low for high-voltage id
	localparam int          DATA_POLL_BIT   = 7;
	localparam int          TOGGLE_FLAG_BIT = 6;
	localparam int          FAIL_FLAG_BIT   = 5;
	localparam int          SECOND_ADDR_BIT = 1;

	// command cycle addresses and data
	localparam logic [18:0] UNLOCK_ADDR1    = 19'h00555;
	localparam logic [18:0] UNLOCK_ADDR2    = 19'h002aa;
	localparam logic [7:0]  UNLOCK_DATA1    = 8'haa;
	localparam logic [7:0]  UNLOCK_DATA2    = 8'h55;
	localparam logic [7:0]  CMD_ID_ENTER    = 8'h90;
	localparam logic [7:0]  CMD_RESET       = 8'hf0;
	localparam logic [7:0]  CMD_PROGRAM     = 8'ha0;
	localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0]  CMD_CHIP_ERASE  = 8'h10;
	localparam logic [7:0]  CMD_SECT_ERASE  = 8'h30;
	localparam logic [7:0]  CMD_SUSPEND     = 8'hb0;
	localparam logic [7:0]  CMD_RESUME      = 8'h30;

	// operations launched through ctrl
	typedef enum logic [3:0] {
		OP_READ       = 4'h0,
		OP_WRITE      = 4'h1,
		OP_RESET      = 4'h2,
		OP_ID_ENTER   = 4'h3,
		OP_PROGRAM    = 4'h4,
		OP_SECT_ERASE = 4'h5,
		OP_CHIP_ERASE = 4'h6,
		OP_SUSPEND    = 4'h7,
		OP_RESUME     = 4'h8,
		OP_HV_ID      = 4'h9
	} pfc_op_t;

	// bus timing
	localparam int          CLK_NS          = 5;
	localparam int          PULSE_NS        = 100;
	localparam int          GAP_NS          = 40;
	localparam int          PULSE_CYC       = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int          GAP_CYC         = (GAP_NS + CLK_NS - 1) / CLK_NS;
endpackage : pfc_pkg

// ===== hdl/pfc_cyc.sv
// one flash bus cycle: read or write, with strobe and gap timing
// assumes start is a one-cycle pulse given only while idle
`timescale 1ns/1ps
`default_nettype none
module pfc_cyc #(
	parameter int PULSE = pfc_pkg::PULSE_CYC,
	parameter int GAP   = pfc_pkg::GAP_CYC
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// request
	input  wire logic        start,
	input  wire logic        wr,
	input  wire logic        hv,
	input  wire logic [18:0] addr,
	input  wire logic [7:0]  wdata,
	output logic             done,
	output logic [7:0]       rdata,
	// flash pins
	output logic [18:0]      fl_addr,
	input  wire logic [7:0]  fl_dq_i,
	output logic [7:0]       fl_dq_o,
	output logic             fl_dq_oe,
	output logic             fl_ce_n,
	output logic             fl_oe_n,
	output logic             fl_we_n,
	output logic             fl_hv
);
	typedef enum logic [4:0] {
		P_IDLE   = 5'b00001,
		P_SETUP  = 5'b00010,
		P_STROBE = 5'b00100,
		P_HOLD   = 5'b01000,
		P_GAP    = 5'b10000
	} pfc_ph_t;

	typedef struct packed {
		pfc_ph_t     ph;
		logic [7:0]  cnt;
		logic        wr;
		logic [18:0] addr;
		logic [7:0]  dq_o;
		logic        dq_oe;
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic        hv;
		logic [7:0]  rdata;
		logic        done;
	} pfc_cyc_st_t;

	pfc_cyc_st_t s;
	pfc_cyc_st_t next_s;

	always_comb
	begin
		next_s      = s;
		next_s.done = 1'b0;
		case (s.ph)
			P_IDLE:
				if (start)
				begin
					// address is set on the same edge that ce falls, and the strobe falls one cycle later [RL5]
					next_s.wr    = wr;
					next_s.addr  = addr;
					next_s.dq_o  = wdata;
					next_s.dq_oe = wr;
					next_s.hv    = hv;
					next_s.ce_n  = 1'b0;
					next_s.ph    = P_SETUP;
				end
			P_SETUP:
			begin
				// write keeps output drive high, read keeps write strobe high [RL2] [RL4]
				next_s.we_n = ~s.wr;
				next_s.oe_n = s.wr;
				next_s.cnt  = 8'(PULSE - 1);
				next_s.ph   = P_STROBE;
			end
			P_STROBE:
				if (s.cnt == '0)
				begin
					next_s.we_n = 1'b1;
					next_s.oe_n = 1'b1;
					if (!s.wr)
						next_s.rdata = fl_dq_i; // [RL2]
					next_s.ph = P_HOLD;
				end
				else
					next_s.cnt = s.cnt - 8'h01;
			P_HOLD:
			begin
				// data stays driven past the we rise, ce rises one cycle later [RL6]
				next_s.ce_n  = 1'b1;
				next_s.dq_oe = 1'b0;
				next_s.hv    = 1'b0;
				next_s.cnt   = 8'(GAP - 1);
				next_s.ph    = P_GAP;
			end
			P_GAP:
				if (s.cnt == '0)
				begin
					next_s.done = 1'b1;
					next_s.ph   = P_IDLE;
				end
				else
					next_s.cnt = s.cnt - 8'h01;
			default:
				next_s.ph = P_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s      <= '0;
			s.ph   <= P_IDLE;
			s.ce_n <= 1'b1;
			s.oe_n <= 1'b1;
			s.we_n <= 1'b1;
		end
		else
			s <= next_s;
	end

	assign done     = s.done;
	assign rdata    = s.rdata;
	assign fl_addr  = s.addr;
	assign fl_dq_o  = s.dq_o;
	assign fl_dq_oe = s.dq_oe;
	assign fl_ce_n  = s.ce_n;
	assign fl_oe_n  = s.oe_n;
	assign fl_we_n  = s.we_n;
	assign fl_hv    = s.hv;
endmodule : pfc_cyc
`default_nettype wire

// ===== sim/pfc_top_assertions.sv
// pin-level checks on the flash side of the host controller
// assumes every flash pin comes straight from a flop clocked by CLK_SYS
`timescale 1ns/1ps
`default_nettype none
module pfc_top_assertions #(
	parameter int PULSE = 20,
	parameter int GAP   = 8
) (
	// clock and reset
	input wire logic        CLK_SYS,
	input wire logic        RST_N,
	// flash pins
	input wire logic [18:0] FL_ADDR,
	input wire logic [7:0]  FL_DQ_O,
	input wire logic        FL_DQ_OE,
	input wire logic        FL_CE_N,
	input wire logic        FL_OE_N,
	input wire logic        FL_WE_N,
	input wire logic        FL_ID_HV
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	logic [7:0] strobe_cnt;
	logic [7:0] idle_cnt;

	// idle count saturates so a long pause never wraps into a false short gap
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			strobe_cnt <= 8'h00;
			idle_cnt   <= 8'hff;
		end
		else
		begin
			strobe_cnt <= (FL_WE_N && FL_OE_N) ? 8'h00 : strobe_cnt + 8'h01;
			idle_cnt   <= !FL_CE_N ? 8'h00 : (idle_cnt == 8'hff ? idle_cnt : idle_cnt + 8'h01);
		end
	end

	property p_read_pins; !FL_OE_N |-> !FL_CE_N && FL_WE_N && !FL_DQ_OE; endproperty
	a_read_pins: assert property (p_read_pins) else $error("read strobe without select");
	property p_write_pins; !FL_WE_N |-> !FL_CE_N && FL_OE_N && FL_DQ_OE; endproperty
	a_write_pins: assert property (p_write_pins) else $error("bad write strobe state");
	property p_release; FL_CE_N |-> !FL_DQ_OE && !FL_ID_HV; endproperty
	a_release: assert property (p_release) else $error("data driven while deselected");
	property p_addr_hold; !FL_CE_N && $past(!FL_CE_N) |-> $stable(FL_ADDR); endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved in a cycle");
	property p_data_hold; FL_DQ_OE && $past(FL_DQ_OE) |-> $stable(FL_DQ_O); endproperty
	a_data_hold: assert property (p_data_hold) else $error("write data moved in a cycle");
	property p_pulse; $rose(FL_WE_N && FL_OE_N) |-> int'(strobe_cnt) == PULSE; endproperty
	a_pulse: assert property (p_pulse) else $error("strobe width wrong");
	property p_ce_last; $rose(FL_WE_N && FL_OE_N) |=> $rose(FL_CE_N) ##1 FL_CE_N; endproperty
	a_ce_last: assert property (p_ce_last) else $error("select not released after strobe");
	property p_gap; $fell(FL_CE_N) |-> int'(idle_cnt) >= GAP + 1; endproperty
	a_gap: assert property (p_gap) else $error("gap between cycles too short");
	property p_hv; FL_ID_HV |-> !FL_CE_N && FL_WE_N && !FL_ADDR[1]; endproperty
	a_hv: assert property (p_hv) else $error("high voltage with bad pins");

	c_write: cover property ($fell(FL_WE_N));
	c_read: cover property ($fell(FL_OE_N));
	c_hv: cover property ($rose(FL_ID_HV));
endmodule : pfc_top_assertions

bind pfc_top pfc_top_assertions #(
	.PULSE(PULSE),
	.GAP  (GAP)
) pfc_top_assertions_inst (
	.CLK_SYS (CLK_SYS),
	.RST_N   (RST_N),
	.FL_ADDR (FL_ADDR),
	.FL_DQ_O (FL_DQ_O),
	.FL_DQ_OE(FL_DQ_OE),
	.FL_CE_N (FL_CE_N),
	.FL_OE_N (FL_OE_N),
	.FL_WE_N (FL_WE_N),
	.FL_ID_HV(FL_ID_HV)
);
`default_nettype wire

// ===== sim/pfc_flash_model.sv
// behavioural byte-wide flash: command decoder, status bits, identification codes
// assumes host strobes; resolves the data wire from both drivers
`timescale 1ns/1ps
`default_nettype none
module pfc_flash_model #(
	parameter int         BUSY_NS   = 1500,
	parameter int         SETTLE_NS = 200,
	parameter logic [7:0] MFR_CODE  = 8'h3c, // arbitrary value
	parameter logic [7:0] DEV_CODE  = 8'h5e  // arbitrary value
) (
	// strobes and address
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic        hv,
	input  wire logic [18:0] addr,
	// data wire and fault control
	input  wire logic [7:0]  host_dq,
	input  wire logic        host_oe,
	input  wire logic        fail_inject,
	output logic [7:0]       dq
);
	typedef enum logic [1:0] {ARRAY, IDENT, BUSY, FAILED} pfc_fmode_t;
	pfc_fmode_t  mode = ARRAY;
	logic [7:0]  mem [int];
	logic [18:0] lat_a;
	logic [7:0]  rdv;
	logic [7:0]  last = 8'h00;
	logic        poll = 1'b0;
	logic        tgl  = 1'b0;
	int          step = 0;
	logic        susp    = 1'b0;
	logic        erasing = 1'b0;
	logic [2:0]  esec    = 3'h0;
	wire         wr_n = ce_n | we_n | ~oe_n; // no write while output drive low
	wire         rd_n = ce_n | oe_n;

	function automatic logic [7:0] rd(input logic [18:0] a);
		return mem.exists(int'(a)) ? mem[int'(a)] : 8'hff;
	endfunction : rd

	task automatic launch(input int kind, input logic [18:0] a, input logic [7:0] d);
		mode = BUSY;
		poll = kind == 0 ? ~d[7] : 1'b0;
		if (kind != 0)
		begin
			erasing = 1'b1;
			esec    = a[18:16];
		end
		// an erase only counts time while it is not suspended
		for (int t = 0; t < BUSY_NS; t += 5)
		begin
			#5;
			if (kind != 0)
				wait (!susp);
		end
		if (kind != 0)
			erasing = 1'b0;
		if (fail_inject)
			mode = FAILED;
		else
		begin
			if (kind == 0)
				mem[int'(a)] = rd(a) & d;
			for (int k = 0; k < 524288 && kind != 0; k++)
				if (kind == 2 || k[18:16] == a[18:16])
					mem.delete(k);
			mode = ARRAY;
		end
	endtask : launch

	task automatic halt_erase();
		#(SETTLE_NS);
		if (erasing)
		begin
			susp = 1'b1;
			mode = ARRAY;
		end
	endtask : halt_erase

	task automatic cmd(input logic [18:0] a, input logic [7:0] d);
		int kind;
		kind = step == 3 ? 0 : (d == 8'h10 ? 2 : 1);
		if (mode == BUSY && erasing && !susp && d == 8'hb0)
			fork
				halt_erase();
			join_none
		if (mode == BUSY)
			return;
		if (susp && step == 0 && d == 8'h30)
		begin
			susp = 1'b0; // erase picks up where it stopped
			mode = BUSY;
		end
		else if (d == 8'hf0 && step != 3)
		begin
			mode = ARRAY;
			step = 0;
		end
		else if (mode != FAILED)
		begin
			if (step == 2 && d == 8'h90)
				mode = IDENT;
			if (step == 3 || step == 6 && (d == 8'h10 || d == 8'h30))
				fork
					launch(kind, a, d);
				join_none
			case (step)
				0: step = (d == 8'haa && a[10:0] == 11'h555) ? 1 : 0;
				1: step = (d == 8'h55 && a[10:0] == 11'h2aa) ? 2 : 0;
				2: step = d == 8'ha0 ? 3 : (d == 8'h80 ? 4 : 0);
				4: step = d == 8'haa ? 5 : 0;
				5: step = d == 8'h55 ? 6 : 0;
				default: step = 0;
			endcase
		end
	endtask : cmd

	always @(negedge rd_n)
		if (mode == BUSY || mode == FAILED)
			tgl = ~tgl;
	always @(negedge wr_n)
		lat_a = addr;
	always @(posedge wr_n)
		cmd(lat_a, host_dq);
	always @*
		if (hv && !addr[1] || mode == IDENT)
			rdv = addr[0] ? DEV_CODE : MFR_CODE;
		else if (mode == ARRAY && !(susp && addr[18:16] == esec))
			rdv = rd(addr);
		else
			rdv = {poll, tgl, mode == FAILED, 5'h00};
	always @(posedge rd_n)
		last = rdv;
	// released lines show the inverse, so a stale byte can never pass for data
	assign dq = host_oe ? host_dq : (!rd_n ? rdv : ~last);
endmodule : pfc_flash_model
`default_nettype wire

// ===== sim/tb_pfc_top.sv
// self-checking bench: apb tasks drive the controller against the flash model
// assumes short strobe and gap parameters to keep the run brief
`timescale 1ns/1ps
`default_nettype none
module tb_pfc_top;
	localparam logic [7:0] MFR = 8'h3c; // arbitrary value
	localparam logic [7:0] DEV = 8'h5e; // arbitrary value
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic        fail_inject = 1'b0;
	logic [31:0] prdata, rv;
	logic        pready, pslverr, ev;
	logic [18:0] fl_addr;
	logic [7:0]  fl_dq_i, fl_dq_o;
	logic        fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_hv;
	int          mismatches = 0;
	int          n_compared = 0;

	always #2.5 clk_sys = ~clk_sys;

	pfc_top #(.PULSE(4), .GAP(2)) pfc_top_inst (.CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .FL_ADDR(fl_addr), .FL_DQ_I(fl_dq_i), .FL_DQ_O(fl_dq_o),
		.FL_DQ_OE(fl_dq_oe), .FL_CE_N(fl_ce_n), .FL_OE_N(fl_oe_n), .FL_WE_N(fl_we_n), .FL_ID_HV(fl_hv));
	pfc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) pfc_flash_model_inst (.ce_n(fl_ce_n),
		.oe_n(fl_oe_n), .we_n(fl_we_n), .hv(fl_hv), .addr(fl_addr), .host_dq(fl_dq_o),
		.host_oe(fl_dq_oe), .fail_inject(fail_inject), .dq(fl_dq_i));

	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			mismatches++;
			$display("ERROR at %0t: no apb answer", $time);
			conclude();
		end
	endtask : apb

	// polls status: a hung operation ends the run instead of the bench
	task automatic op(input pfc_pkg::pfc_op_t code, input logic [18:0] a, input logic [7:0] d);
		int n;
		n = 0;
		apb(1'b1, pfc_pkg::REG_ADDR, {13'h0000, a});
		apb(1'b1, pfc_pkg::REG_WDATA, {24'h000000, d});
		apb(1'b1, pfc_pkg::REG_CTRL, {28'h0000000, code});
		do
		begin
			apb(1'b0, pfc_pkg::REG_STATUS, 32'h0);
			n++;
		end
		while (rv[pfc_pkg::ST_BUSY] !== 1'b0 && n < 2000);
		if (n >= 2000)
		begin
			mismatches++;
			$display("ERROR at %0t: operation never ended", $time);
			conclude();
		end
	endtask : op

	task automatic rdop(input pfc_pkg::pfc_op_t code, input logic [18:0] a, input logic [7:0] exp);
		op(code, a, 8'h00);
		apb(1'b0, pfc_pkg::REG_RDATA, 32'h0);
		chk(rv, {24'h000000, exp});
	endtask : rdop

	task automatic stat(input logic [31:0] exp);
		apb(1'b0, pfc_pkg::REG_STATUS, 32'h0);
		chk(rv, exp);
	endtask : stat

	initial
	begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		stat(32'h00000000);
		apb(1'b0, 12'h014, 32'h0);
		chk({rv[31:1], ev}, 32'h00000001);
		rdop(pfc_pkg::OP_READ, 19'h12345, 8'hff);
		$display("test reset done");
		op(pfc_pkg::OP_PROGRAM, 19'h3abcd, 8'h5a);
		stat(32'h00000030);
		op(pfc_pkg::OP_PROGRAM, 19'h7ffff, 8'h81);
		rdop(pfc_pkg::OP_READ, 19'h3abcd, 8'h5a);
		rdop(pfc_pkg::OP_READ, 19'h7ffff, 8'h81);
		$display("test program done");
		op(pfc_pkg::OP_ID_ENTER, 19'h00000, 8'h00);
		stat(32'h00000004);
		rdop(pfc_pkg::OP_READ, 19'h00000, MFR);
		rdop(pfc_pkg::OP_READ, 19'h00001, DEV);
		rdop(pfc_pkg::OP_READ, 19'h50000, MFR);
		op(pfc_pkg::OP_RESET, 19'h00000, 8'h00);
		rdop(pfc_pkg::OP_READ, 19'h3abcd, 8'h5a);
		rdop(pfc_pkg::OP_HV_ID, 19'h00003, DEV);
		rdop(pfc_pkg::OP_HV_ID, 19'h00002, MFR);
		rdop(pfc_pkg::OP_READ, 19'h3abcd, 8'h5a);
		$display("test identification done");
		fail_inject <= 1'b1;
		op(pfc_pkg::OP_PROGRAM, 19'h1000f, 8'h00);
		stat(32'h00000012);
		fail_inject <= 1'b0;
		rdop(pfc_pkg::OP_READ, 19'h1000f, 8'hff);
		$display("test failure done");
		op(pfc_pkg::OP_SECT_ERASE, 19'h30000, 8'h00);
		rdop(pfc_pkg::OP_READ, 19'h3abcd, 8'hff);
		rdop(pfc_pkg::OP_READ, 19'h7ffff, 8'h81);
		op(pfc_pkg::OP_CHIP_ERASE, 19'h00000, 8'h00);
		rdop(pfc_pkg::OP_READ, 19'h7ffff, 8'hff);
		$display("test erase done");
		op(pfc_pkg::OP_WRITE, 19'h00555, 8'haa);
		op(pfc_pkg::OP_WRITE, 19'h002aa, 8'h55);
		op(pfc_pkg::OP_WRITE, 19'h00555, 8'h80);
		op(pfc_pkg::OP_WRITE, 19'h00555, 8'haa);
		op(pfc_pkg::OP_WRITE, 19'h002aa, 8'h55);
		op(pfc_pkg::OP_WRITE, 19'h30000, 8'h30);
		op(pfc_pkg::OP_SUSPEND, 19'h7ffff, 8'h00);
		stat(32'h00000078);
		op(pfc_pkg::OP_PROGRAM, 19'h1000f, 8'h3c);
		stat(32'h00000018);
		rdop(pfc_pkg::OP_READ, 19'h1000f, 8'h3c);
		op(pfc_pkg::OP_READ, 19'h30000, 8'h00);
		apb(1'b0, pfc_pkg::REG_RDATA, 32'h0);
		chk(rv & 32'hffffff20, 32'h00000000);
		op(pfc_pkg::OP_RESUME, 19'h7ffff, 8'h00);
		stat(32'h00000070);
		rdop(pfc_pkg::OP_READ, 19'h30000, 8'hff);
		$display("test suspend done");
		conclude();
	end
endmodule : tb_pfc_top
`default_nettype wire
